//--- bsp_pkg.sv
package bsp_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] OFS_F_DIR   = 4'h0;
   localparam logic [3:0] OFS_F_PINS  = 4'h1;
   localparam logic [3:0] OFS_F_LATCH = 4'h2;
   localparam logic [3:0] OFS_G_DIR   = 4'h3;
   localparam logic [3:0] OFS_G_PINS  = 4'h4;
   localparam logic [3:0] OFS_G_LATCH = 4'h5;
   localparam logic [3:0] OFS_AN_ONE  = 4'h6;
   localparam logic [3:0] OFS_AN_TWO  = 4'h7;
   localparam logic [3:0] OFS_MEMCTL  = 4'h8;
   localparam logic [3:0] OFS_SEL2    = 4'h9;
   localparam logic [3:0] OFS_SELIO   = 4'ha;
   localparam logic [3:0] OFS_PPCTL   = 4'hb;
   localparam logic [3:0] OFS_STATUS  = 4'hc;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_F_DIR   = 8'hff;
   localparam logic [7:0] RST_F_LATCH = 8'h00;
   localparam logic [4:0] RST_G_DIR   = 5'h1f;
   localparam logic [4:0] RST_G_LATCH = 5'h00;
   localparam logic [7:0] RST_AN      = 8'h00;
   localparam logic [7:0] RST_MEMCTL  = 8'h00;
   // Select configs come up nonzero so the select pins start as bus signals.
   localparam logic [7:0] RST_SEL     = 8'hff;
   localparam logic [7:0] RST_PPCTL   = 8'h00;

   // ----------------------------------------------------------------
   // Field positions and codes
   // ----------------------------------------------------------------
   localparam int          MEM_EBD_BIT  = 7;
   localparam logic [7:0]  MEM_WMASK    = 8'hf3;
   localparam logic [1:0]  WMODE_BYTE   = 2'h1;
   localparam logic [7:0]  AN_WMASK     = 8'h3f;
   localparam logic [3:0]  AN_ALL_DIG   = 4'hf;
   localparam int          PP_LOCK2_BIT = 3;
   localparam int          PP_LOCK1_BIT = 2;

   typedef enum logic [1:0] {
      BSP_LK_IDLE = 2'b00,
      BSP_LK_HALF = 2'b01,
      BSP_LK_OPEN = 2'b11
   } bsp_lock_e;

endpackage

//--- bsp_pin_mux.sv
`timescale 1ns/10ps
`default_nettype none

// One bit of a port: owner function or port registers drive the pin.
module bsp_pin_mux (
   // Port registers
   input  wire logic i_dir,
   input  wire logic i_latch,
   // Alternate function
   input  wire logic i_alt_own,
   input  wire logic i_alt_oe,
   input  wire logic i_alt_out,
   // Pin
   output logic      o_pin_out,
   output logic      o_pin_oe
);

   always_comb begin
      if (i_alt_own) begin
         o_pin_out = i_alt_out;
         o_pin_oe  = i_alt_oe;
      end else begin
         o_pin_out = i_latch;
         o_pin_oe  = ~i_dir;
      end
   end

endmodule

`default_nettype wire

//--- bsp_ports_fg.sv
`timescale 1ns/10ps
`default_nettype none

module bsp_ports_fg #(
   parameter bit LARGE_VARIANT = 1'b1
) (
   // Clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   // Register port
   input  wire logic [3:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   // Execution state from the core
   input  wire logic       i_exec_internal,
   input  wire logic       i_bus_16bit,
   // Bus function signals from the memory interface
   input  wire logic       i_sel_io,
   input  wire logic       i_sel_one,
   input  wire logic       i_sel_two,
   input  wire logic       i_addr16,
   input  wire logic       i_low_sel,
   input  wire logic       i_high_sel,
   input  wire logic [4:0] i_g_bus_out,
   // Sixth port pin
   input  wire logic [7:0] i_f_pin,
   output logic      [7:0] o_f_out,
   output logic      [7:0] o_f_oe,
   output logic      [2:0] o_f_analog,
   // Seventh port pin
   input  wire logic [4:0] i_g_pin,
   output logic      [4:0] o_g_out,
   output logic      [4:0] o_g_oe,
   // Lock state
   output logic            o_lock_open
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]         f_dir;
      logic [7:0]         f_latch;
      logic [4:0]         g_dir;
      logic [4:0]         g_latch;
      logic [7:0]         an_one;
      logic [7:0]         an_two;
      logic [7:0]         memctl;
      logic [7:0]         sel2;
      logic [7:0]         selio;
      logic [7:0]         ppctl;
      bsp_pkg::bsp_lock_e lock;
      logic [7:0]         rdata;
   } bsp_state_s;

   bsp_state_s st_reg;
   bsp_state_s st_next;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
      hit = (a == o);
   endfunction

   // ----------------------------------------------------------------
   // Ownership
   // ----------------------------------------------------------------
   logic       bus_off;
   logic       analog_on;
   logic       sel_busy;
   logic       bytesel_on;
   logic       f4_own;
   logic       g_io;
   logic [7:0] f_own;
   logic [7:0] f_alt;
   logic [7:0] f_alt_oe;
   logic [4:0] g_own;

   always_comb begin
      bus_off    = st_reg.memctl[bsp_pkg::MEM_EBD_BIT];
      analog_on  = (st_reg.an_two[3:0] != bsp_pkg::AN_ALL_DIG);
      sel_busy   = LARGE_VARIANT ? ((st_reg.sel2 != 8'h00) || (st_reg.selio != 8'h00))
                                 : (st_reg.selio != 8'h00);
      bytesel_on = i_bus_16bit && (st_reg.memctl[1:0] == bsp_pkg::WMODE_BYTE);
      f4_own     = LARGE_VARIANT ? sel_busy
                                 : ~(bus_off && i_exec_internal);
      g_io       = bus_off && i_exec_internal;
      f_own      = {bytesel_on, bytesel_on, sel_busy, f4_own, sel_busy,
                    analog_on, analog_on, analog_on};
      f_alt      = {i_high_sel, i_low_sel, i_sel_one,
                    (LARGE_VARIANT ? i_sel_two : i_addr16), i_sel_io,
                    3'h0};
      f_alt_oe   = {5'h1f, 3'h0};
      g_own      = {~g_io, ~g_io && ~(~i_exec_internal && ~i_bus_16bit),
                    ~g_io, ~g_io, ~g_io};
   end

   // Analog pins are released to the converter; driver off.
   assign o_f_analog = f_own[2:0];

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_fbit
         bsp_pin_mux u_mux (
            .i_dir     (st_reg.f_dir[gi]),
            .i_latch   (st_reg.f_latch[gi]),
            .i_alt_own (f_own[gi]),
            .i_alt_oe  (f_alt_oe[gi]),
            .i_alt_out (f_alt[gi]),
            .o_pin_out (o_f_out[gi]),
            .o_pin_oe  (o_f_oe[gi])
         );
      end
      for (gi = 0; gi < 5; gi++) begin : g_gbit
         bsp_pin_mux u_mux (
            .i_dir     (st_reg.g_dir[gi]),
            .i_latch   (st_reg.g_latch[gi]),
            .i_alt_own (g_own[gi]),
            .i_alt_oe  (1'b1),
            .i_alt_out (i_g_bus_out[gi]),
            .o_pin_out (o_g_out[gi]),
            .o_pin_oe  (o_g_oe[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Register file and lock
   // ----------------------------------------------------------------
   // The lock only opens on two writes in a row that set the second
   // bit and then the first; any other write closes it, so a stray
   // write between the steps cannot leave it armed; a read does not touch it.
   logic [7:0] pp_wr;

   always_comb begin
      st_next = st_reg;
      pp_wr   = 8'h00;
      if (i_wr) begin
         if (hit(i_addr, bsp_pkg::OFS_F_DIR))   st_next.f_dir   = i_wdata;
         if (hit(i_addr, bsp_pkg::OFS_F_PINS))  st_next.f_latch = i_wdata;
         if (hit(i_addr, bsp_pkg::OFS_F_LATCH)) st_next.f_latch = i_wdata;
         if (hit(i_addr, bsp_pkg::OFS_G_DIR))   st_next.g_dir   = i_wdata[4:0];
         if (hit(i_addr, bsp_pkg::OFS_G_PINS))  st_next.g_latch = i_wdata[4:0];
         if (hit(i_addr, bsp_pkg::OFS_G_LATCH)) st_next.g_latch = i_wdata[4:0];
         if (hit(i_addr, bsp_pkg::OFS_AN_ONE))  st_next.an_one  = i_wdata;
         if (hit(i_addr, bsp_pkg::OFS_AN_TWO))
            st_next.an_two = i_wdata & bsp_pkg::AN_WMASK;
         if (hit(i_addr, bsp_pkg::OFS_MEMCTL))
            st_next.memctl = i_wdata & bsp_pkg::MEM_WMASK;
         if (hit(i_addr, bsp_pkg::OFS_SELIO))   st_next.selio   = i_wdata;
         if (hit(i_addr, bsp_pkg::OFS_SEL2) && (st_reg.lock == bsp_pkg::BSP_LK_OPEN))
            st_next.sel2 = i_wdata;
         if (hit(i_addr, bsp_pkg::OFS_PPCTL)) begin
            pp_wr          = i_wdata;
            st_next.ppctl  = i_wdata;
         end
         case (st_reg.lock)
            bsp_pkg::BSP_LK_IDLE: begin
               if (hit(i_addr, bsp_pkg::OFS_PPCTL) && pp_wr[bsp_pkg::PP_LOCK2_BIT]
                   && !pp_wr[bsp_pkg::PP_LOCK1_BIT])
                  st_next.lock = bsp_pkg::BSP_LK_HALF;
            end
            bsp_pkg::BSP_LK_HALF: begin
               if (hit(i_addr, bsp_pkg::OFS_PPCTL) && pp_wr[bsp_pkg::PP_LOCK2_BIT]
                   && pp_wr[bsp_pkg::PP_LOCK1_BIT])
                  st_next.lock = bsp_pkg::BSP_LK_OPEN;
               else
                  st_next.lock = bsp_pkg::BSP_LK_IDLE;
            end
            default: begin
               st_next.lock = bsp_pkg::BSP_LK_IDLE;
            end
         endcase
         // A fresh first step re-arms from any state, so a repeated or
         // interrupted unlock attempt starts over instead of being lost.
         if (hit(i_addr, bsp_pkg::OFS_PPCTL) && pp_wr[bsp_pkg::PP_LOCK2_BIT]
             && !pp_wr[bsp_pkg::PP_LOCK1_BIT])
            st_next.lock = bsp_pkg::BSP_LK_HALF;
      end
      st_next.rdata = 8'h00;
      if (i_rd) begin
         case (i_addr)
            bsp_pkg::OFS_F_DIR:   st_next.rdata = st_reg.f_dir;
            bsp_pkg::OFS_F_PINS:  st_next.rdata = i_f_pin & ~{5'h00, o_f_analog};
            bsp_pkg::OFS_F_LATCH: st_next.rdata = st_reg.f_latch;
            bsp_pkg::OFS_G_DIR:   st_next.rdata = {3'h0, st_reg.g_dir};
            bsp_pkg::OFS_G_PINS:  st_next.rdata = {3'h0, i_g_pin};
            bsp_pkg::OFS_G_LATCH: st_next.rdata = {3'h0, st_reg.g_latch};
            bsp_pkg::OFS_AN_ONE:  st_next.rdata = st_reg.an_one;
            bsp_pkg::OFS_AN_TWO:  st_next.rdata = st_reg.an_two;
            bsp_pkg::OFS_MEMCTL:  st_next.rdata = st_reg.memctl;
            bsp_pkg::OFS_SEL2:    st_next.rdata = st_reg.sel2;
            bsp_pkg::OFS_SELIO:   st_next.rdata = st_reg.selio;
            bsp_pkg::OFS_PPCTL:   st_next.rdata = st_reg.ppctl;
            bsp_pkg::OFS_STATUS:  st_next.rdata = {f_own[7:3], g_io, bytesel_on,
                                                   st_reg.lock == bsp_pkg::BSP_LK_OPEN};
            default:              st_next.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg.f_dir   <= bsp_pkg::RST_F_DIR;
         st_reg.f_latch <= bsp_pkg::RST_F_LATCH;
         st_reg.g_dir   <= bsp_pkg::RST_G_DIR;
         st_reg.g_latch <= bsp_pkg::RST_G_LATCH;
         st_reg.an_one  <= bsp_pkg::RST_AN;
         st_reg.an_two  <= bsp_pkg::RST_AN;
         st_reg.memctl  <= bsp_pkg::RST_MEMCTL;
         st_reg.sel2    <= bsp_pkg::RST_SEL;
         st_reg.selio   <= bsp_pkg::RST_SEL;
         st_reg.ppctl   <= bsp_pkg::RST_PPCTL;
         st_reg.lock    <= bsp_pkg::BSP_LK_IDLE;
         st_reg.rdata   <= 8'h00;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_rdata     = st_reg.rdata;
   assign o_lock_open = (st_reg.lock == bsp_pkg::BSP_LK_OPEN);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_arm;
      i_wr && hit(i_addr, bsp_pkg::OFS_PPCTL) && i_wdata[3] && !i_wdata[2];
   endsequence
   sequence s_fire;
      i_wr && hit(i_addr, bsp_pkg::OFS_PPCTL) && i_wdata[3] && i_wdata[2];
   endsequence

   a_dir_input_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (!f_own[7] && st_reg.f_dir[7]) |-> !o_f_oe[7])
      else $error("input pin drives");
   a_dir_drive_latch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (!g_own[0] && !st_reg.g_dir[0]) |-> (o_g_oe[0] && o_g_out[0] == st_reg.g_latch[0]))
      else $error("output pin not from latch");
   a_latch_readback: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_wr && hit(i_addr, bsp_pkg::OFS_F_LATCH)) ##1 (i_rd && hit(i_addr, bsp_pkg::OFS_F_LATCH))
      |=> (o_rdata == $past(i_wdata, 2)))
      else $error("latch readback wrong");
   a_pins_read: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_rd && hit(i_addr, bsp_pkg::OFS_G_PINS)) |=> (o_rdata == {3'h0, $past(i_g_pin)}))
      else $error("pin read wrong");
   a_analog_digital: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_wr && hit(i_addr, bsp_pkg::OFS_AN_TWO) && i_wdata == 8'h0f) |=> (o_f_analog == 3'h0))
      else $error("analog pins not released");
   a_byte_select: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (st_reg.memctl[1:0] != bsp_pkg::WMODE_BYTE) |-> !f_own[7] && !f_own[6])
      else $error("byte selects kept");
   a_lock_open: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (s_arm ##1 s_fire) |=> o_lock_open ##1 (!$past(i_wr) || !o_lock_open))
      else $error("lock not opened");
   a_sel2_guard: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_wr && hit(i_addr, bsp_pkg::OFS_SEL2) && !o_lock_open) |=> $stable(st_reg.sel2))
      else $error("locked register written");
   a_port_g_io: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !(bus_off && i_exec_internal) |-> (g_own[4] && g_own[0]))
      else $error("seventh port left bus");
   a_keep_regs: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (f_own[5] && !i_wr) |=> $stable(st_reg.f_dir) && $stable(st_reg.f_latch))
      else $error("port regs changed");

   // ----------------------------------------------------------------
   // Reset, ownership and register checks
   // ----------------------------------------------------------------
   // Reset values are checked on the first edge after release, when the
   // registers still hold them; an edge inside reset only sees the disable,
   // so this is the earliest sample that means anything.
   a_bus_off_frees: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (bus_off && i_exec_internal) |-> (g_own == 5'h00))
      else $error("bus kept seventh port");
   a_analog_oe_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      analog_on |-> (o_f_oe[2:0] == 3'h0) && (o_f_analog == 3'h7))
      else $error("analog pin driven");
   a_analog_pins_read: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_rd && hit(i_addr, bsp_pkg::OFS_F_PINS) && analog_on) |=> (o_rdata[2:0] == 3'h0))
      else $error("analog pin read not zero");
   a_reset_analog: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> (o_f_analog == 3'h7))
      else $error("analog pins not default");
   a_select_pins: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      sel_busy |-> (o_f_oe[3] && o_f_oe[5] && o_f_out[3] == i_sel_io && o_f_out[5] == i_sel_one))
      else $error("select pins wrong");
   a_bit4_function: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      f_own[4] |-> (o_f_oe[4] && o_f_out[4] == (LARGE_VARIANT ? i_sel_two : i_addr16)))
      else $error("bit four function wrong");
   a_select_release: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      ((st_reg.selio == 8'h00) && (!LARGE_VARIANT || st_reg.sel2 == 8'h00))
      |-> !f_own[5] && !f_own[3])
      else $error("select pins not released");
   a_small_bit4: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (!LARGE_VARIANT && !(bus_off && i_exec_internal)) |-> f_own[4])
      else $error("bit four released early");
   a_reset_sixth: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> (f_own[5:3] == 3'h7))
      else $error("sixth port bus pins not default");
   a_bus_controls: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (g_own == 5'h1f) |-> (o_g_oe == 5'h1f) && (o_g_out == i_g_bus_out))
      else $error("bus controls not driven");
   a_high_write_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (!i_exec_internal && !i_bus_16bit) |-> !g_own[3] && g_own[2])
      else $error("high write kept in byte mode");
   a_reset_seventh: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> ((g_own | 5'h08) == 5'h1f))
      else $error("seventh port not bus after reset");
   a_latch_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_wr && hit(i_addr, bsp_pkg::OFS_F_PINS)) |=> (st_reg.f_latch == $past(i_wdata)))
      else $error("pins write missed latch");
   a_seventh_read: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_rd && hit(i_addr, bsp_pkg::OFS_G_LATCH)) |=> (o_rdata[7:5] == 3'h0))
      else $error("seventh port upper bits set");
   a_keep_seventh: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (g_own[2] && !i_wr) |=> $stable(st_reg.g_latch) && $stable(st_reg.g_dir))
      else $error("seventh port regs changed");

endmodule

`default_nettype wire

//--- bsp_ext_dev.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Far-side memory and I/O devices on the shared pins
// ----------------------------------------------------------------
// A released pin carries a far-side pattern that the testbench redraws at random each bus cycle,
// so a stale level only matches a driven one by chance.
module bsp_ext_dev (
   // Drive from the port
   input  wire logic [7:0] i_f_out,
   input  wire logic [7:0] i_f_oe,
   input  wire logic [4:0] i_g_out,
   input  wire logic [4:0] i_g_oe,
   // Far-side pattern
   input  wire logic [7:0] i_f_drv,
   input  wire logic [4:0] i_g_drv,
   // Resolved levels
   output logic      [7:0] o_f_pin,
   output logic      [4:0] o_g_pin
);
   assign o_f_pin = (i_f_oe & i_f_out) | (~i_f_oe & i_f_drv);
   assign o_g_pin = (i_g_oe & i_g_out) | (~i_g_oe & i_g_drv);
endmodule

`default_nettype wire

//--- bsp_ports_fg_tb.sv
`timescale 1ns/10ps
`default_nettype none

module bsp_ports_fg_tb;
   logic        i_mclk, i_rst_n, i_wr, i_rd, i_exec_internal, i_bus_16bit, o_lock_open;
   logic        i_sel_io, i_sel_one, i_sel_two, i_addr16, i_low_sel, i_high_sel;
   logic [3:0]  i_addr;
   logic [7:0]  i_wdata, o_rdata, i_f_pin, o_f_out, o_f_oe, f_drv, s_out, s_oe;
   logic [4:0]  i_g_bus_out, i_g_pin, o_g_out, o_g_oe, g_drv;
   logic [2:0]  o_f_analog;
   int          n_fail, total_checks, cycles;
   logic [31:0] seed;
   logic [7:0]  m_fdir, m_flat, m_an1, m_an2, m_mem, m_sel2, m_selio, m_pp, exp_rd;
   logic [4:0]  m_gdir, m_glat;
   logic [1:0]  m_lk;
   logic        rd_pend;

   bsp_ports_fg #(.LARGE_VARIANT(1'b1)) bsp_ports_fg_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_exec_internal(i_exec_internal), .i_bus_16bit(i_bus_16bit), .i_sel_io(i_sel_io),
      .i_sel_one(i_sel_one), .i_sel_two(i_sel_two), .i_addr16(i_addr16),
      .i_low_sel(i_low_sel), .i_high_sel(i_high_sel), .i_g_bus_out(i_g_bus_out),
      .i_f_pin(i_f_pin), .o_f_out(o_f_out), .o_f_oe(o_f_oe), .o_f_analog(o_f_analog),
      .i_g_pin(i_g_pin), .o_g_out(o_g_out), .o_g_oe(o_g_oe), .o_lock_open(o_lock_open));
   // The small variant shares every input; only its select pins and its bit four are judged.
   bsp_ports_fg #(.LARGE_VARIANT(1'b0)) bsp_ports_fg_small_i (.i_mclk(i_mclk),
      .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(), .i_exec_internal(i_exec_internal), .i_bus_16bit(i_bus_16bit),
      .i_sel_io(i_sel_io), .i_sel_one(i_sel_one), .i_sel_two(i_sel_two),
      .i_addr16(i_addr16), .i_low_sel(i_low_sel), .i_high_sel(i_high_sel),
      .i_g_bus_out(i_g_bus_out), .i_f_pin(i_f_pin), .o_f_out(s_out), .o_f_oe(s_oe),
      .o_f_analog(), .i_g_pin(i_g_pin), .o_g_out(), .o_g_oe(), .o_lock_open());
   bsp_ext_dev bsp_ext_dev_i (.i_f_out(o_f_out), .i_f_oe(o_f_oe), .i_g_out(o_g_out),
      .i_g_oe(o_g_oe), .i_f_drv(f_drv), .i_g_drv(g_drv), .o_f_pin(i_f_pin), .o_g_pin(i_g_pin));

   initial i_mclk = 1'b0;
   always #10 i_mclk = ~i_mclk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (n_fail == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Register model
   // ----------------------------------------------------------------
   function automatic logic [7:0] mread(input logic [3:0] a);
      case (a)
         4'h0: return m_fdir;
         4'h1: return i_f_pin & ~{5'h00, {3{m_an2[3:0] != 4'hf}}};
         4'h2: return m_flat;
         4'h3: return {3'h0, m_gdir};
         4'h4: return {3'h0, i_g_pin};
         4'h5: return {3'h0, m_glat};
         4'h6: return m_an1;
         4'h7: return m_an2 & 8'h3f;
         4'h8: return m_mem & 8'hf3;
         4'h9: return m_sel2;
         4'ha: return m_selio;
         4'hb: return m_pp;
         4'hc: return {{2{i_bus_16bit && m_mem[1:0] == 2'h1}},
                       {3{m_sel2 != 8'h00 || m_selio != 8'h00}}, m_mem[7] && i_exec_internal,
                       i_bus_16bit && m_mem[1:0] == 2'h1, m_lk == 2'h2};
         default: return 8'h00;
      endcase
   endfunction

   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         m_fdir = 8'hff;
         m_flat = 8'h00;
         m_gdir = 5'h1f;
         m_glat = 5'h00;
         m_an1 = 8'h00;
         m_an2 = 8'h00;
         m_mem = 8'h00;
         m_sel2 = 8'hff;
         m_selio = 8'hff;
         m_pp = 8'h00;
         m_lk = 2'h0;
         rd_pend = 1'b0;
      end else begin
         rd_pend = i_rd;
         exp_rd = mread(i_addr);
         if (i_wr) begin
            case (i_addr)
               4'h0: m_fdir = i_wdata;
               4'h1, 4'h2: m_flat = i_wdata;
               4'h3: m_gdir = i_wdata[4:0];
               4'h4, 4'h5: m_glat = i_wdata[4:0];
               4'h6: m_an1 = i_wdata;
               4'hb: m_pp = i_wdata;
               4'h7: m_an2 = i_wdata;
               4'h8: m_mem = i_wdata;
               4'h9: if (m_lk == 2'h2) m_sel2 = i_wdata;
               4'ha: m_selio = i_wdata;
               default: ;
            endcase
            if (i_addr == 4'hb && i_wdata[3:2] == 2'h2) m_lk = 2'h1;
            else if (m_lk == 2'h1 && i_addr == 4'hb && i_wdata[3:2] == 2'h3) m_lk = 2'h2;
            else m_lk = 2'h0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin and read-data comparison, once settled in every cycle
   // ----------------------------------------------------------------
   always @(negedge i_mclk) begin
      logic [7:0] fb, fo, an;
      logic [4:0] gb, go;
      logic       cs, b4;
      an = {5'h00, {3{m_an2[3:0] != 4'hf}}};
      cs = (m_sel2 != 8'h00) || (m_selio != 8'h00);
      fb = {{2{i_bus_16bit && m_mem[1:0] == 2'h1}}, cs, cs, cs, 3'h0};
      fo = (fb & {i_high_sel, i_low_sel, i_sel_one, i_sel_two, i_sel_io, 3'h0}) | (~fb & m_flat);
      fo = fo & (fb | (~m_fdir & ~an));
      gb = (m_mem[7] && i_exec_internal) ? 5'h00 : 5'h1f;
      if (!i_exec_internal && !i_bus_16bit) gb[3] = 1'b0;
      go = ((gb & i_g_bus_out) | (~gb & m_glat)) & (gb | ~m_gdir);
      cs = m_selio != 8'h00;
      b4 = !(m_mem[7] && i_exec_internal);
      if (i_rst_n) begin
         chk(o_f_oe, fb | (~m_fdir & ~an));
         chk(o_f_out & o_f_oe, fo);
         chk({5'h00, o_f_analog}, an);
         chk({3'h0, o_g_oe}, {3'h0, gb | ~m_gdir});
         chk({3'h0, o_g_out & o_g_oe}, {3'h0, go});
         chk({5'h00, s_oe[5:3]}, {5'h00, {cs, b4, cs} | ~m_fdir[5:3]});
         chk({7'h00, s_out[4] & b4}, {7'h00, i_addr16 & b4});
         chk({7'h00, o_lock_open}, {7'h00, m_lk == 2'h2});
         chk(o_rdata, rd_pend ? exp_rd : 8'h00);
      end
   end

   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         $display("ERROR %0t run did not finish", $time);
         stop_test();
      end
   end

   // One bus cycle; the side inputs and far-side pattern move every cycle.
   task automatic op(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
      logic [31:0] x;
      x = rnd();
      @(posedge i_mclk);
      i_wr <= w;
      i_rd <= r;
      i_addr <= a;
      i_wdata <= d;
      {i_exec_internal, i_bus_16bit, i_sel_io, i_sel_one, i_sel_two, i_addr16} <= x[5:0];
      {i_low_sel, i_high_sel, i_g_bus_out} <= x[12:6];
      {f_drv, g_drv} <= x[25:13];
   endtask

   task automatic unlock_write(input logic [7:0] d);
      op(1'b1, 1'b0, 4'hb, 8'h08);
      op(1'b1, 1'b0, 4'hb, 8'h0c);
      op(1'b1, 1'b0, 4'h9, d);
   endtask

   initial begin
      {i_rst_n, i_wr, i_rd, i_addr, i_wdata, i_exec_internal, i_bus_16bit} = '0;
      {i_sel_io, i_sel_one, i_sel_two, i_addr16, i_low_sel, i_high_sel} = '0;
      {i_g_bus_out, f_drv, g_drv} = '0;
      {n_fail, total_checks, cycles} = '0;
      seed = 32'he25b;
      repeat (5) @(posedge i_mclk);
      @(negedge i_mclk) i_rst_n = 1'b1;
      for (int a = 0; a < 16; a++) op(1'b0, 1'b1, a[3:0], 8'h00);
      op(1'b1, 1'b0, 4'h7, 8'h0f);
      op(1'b1, 1'b0, 4'h0, 8'h00);
      op(1'b1, 1'b0, 4'h1, 8'ha5);
      op(1'b0, 1'b1, 4'h2, 8'h00);
      unlock_write(8'h5a);
      op(1'b1, 1'b0, 4'h9, 8'h00);
      op(1'b1, 1'b0, 4'hb, 8'h04);
      op(1'b1, 1'b0, 4'hb, 8'h0c);
      op(1'b1, 1'b0, 4'h9, 8'h33);
      op(1'b0, 1'b1, 4'h9, 8'h00);
      unlock_write(8'h00);
      for (int i = 0; i < 4000; i++) begin
         logic [31:0] y;
         logic [3:0]  a;
         y = rnd();
         a = y[7:4];
         if (y[1:0] == 2'h1 && (a == 4'h6 || a == 4'h9 || a >= 4'hb)) a = 4'h8;
         if (i == 2000) begin
            op(1'b0, 1'b0, 4'h0, 8'h00);
            @(negedge i_mclk) i_rst_n = 1'b0;
            repeat (2) @(negedge i_mclk);
            i_rst_n = 1'b1;
            unlock_write(8'h00);
         end
         op(y[1:0] == 2'h1, y[1:0] == 2'h2, a, y[17:16] == 2'h0 ? 8'h00 : y[15:8]);
      end
      op(1'b0, 1'b0, 4'h0, 8'h00);
      repeat (2) @(posedge i_mclk);
      stop_test();
   end
endmodule

`default_nettype wire
